// [logic/pgm_pad_monitor.sv]
// Purpose: multi-purpose pin output control, level readback, monitor pin select
// Assumes: byte register port, read data one cycle after the read strobe
// Notes: transmit and receive status come from logic outside this block
//
// Notes on behaviour
// R01: enable bit makes its pin an output
// R02: bit 6 overrides clock output function
// R03: scan active masks enable bits 3..0
// R04: enabled pins driven from output value register
// R05: input register returns sampled pin levels
// R06: common bit order across pad registers
// R07: bit 7 selects fast pad switching
// R08: select codes 0h,1h float monitor pin
// R09: codes 2h,3h drive constant low, high
// R10: codes 4h,5h show transmit envelope, active
// R11: code 6h shows coprocessor link signal
// R12: code 7h shows receive envelope
// R13: codes 8h,9h show receive active, bit
// R14: reserved codes float monitor pin
// R15: reset clears all; reserved bits read zero
`timescale 1ns/1ps
module pgm_pad_monitor
    import pgm_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [7:0] reg_address,
    input wire logic [7:0] reg_write_data,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_read_data,
    input wire logic boundary_scan_active,
    input wire logic [7:0] pad_in,
    output logic [7:0] pad_out,
    output logic [7:0] pad_oe_n,
    output logic clock_output_function_off,
    output logic fast_switch_bit,
    input wire logic clock_output_function,
    input wire logic tx_envelope,
    input wire logic tx_active,
    input wire logic secure_coprocessor_link_signal,
    input wire logic rx_envelope,
    input wire logic rx_active,
    input wire logic rx_bit,
    output logic monitor_output_pin_out,
    output logic monitor_output_pin_oe_n
);
    logic reset_meta;
    logic reset_sync_n;
    logic scan_active_meta;
    logic scan_active_a;
    logic scan_active_b;
    logic scan_active;
    logic [7:0] pad_output_enable;
    logic [7:0] pad_output_value;
    logic [3:0] monitor_select_field;
    logic fast_switch;
    logic [7:0] pad_input_level;
    logic [7:0] effective_enable;
    logic [7:0] next_pad_out;
    logic [7:0] next_read_data;
    logic next_monitor_value;
    logic next_monitor_drive;
    logic hit_enable;
    logic hit_value;
    logic hit_input;
    logic hit_select;
    logic [7:0] select_readback;

    // release of reset is synchronised; assertion stays asynchronous
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reset_meta <= 1'b0;
            reset_sync_n <= 1'b0;
        end else begin
            reset_meta <= 1'b1;
            reset_sync_n <= reset_meta;
        end
    end

    // the scan strap is a static level but still crosses in
    always_ff @(posedge clock or negedge reset_sync_n) begin
        if (!reset_sync_n) begin
            scan_active_meta <= 1'b0;
            scan_active_a <= 1'b0;
            scan_active_b <= 1'b0;
            scan_active <= 1'b0;
        end else begin
            scan_active_meta <= boundary_scan_active;
            scan_active_a <= scan_active_meta;
            scan_active_b <= scan_active_a;
            if (scan_active_a == scan_active_b) begin
                scan_active <= scan_active_b;
            end
        end
    end

    pgm_sync #(
        .WIDTH(PAD_COUNT)
    ) u_pad_sync (
        .clock(clock),
        .reset_n(reset_sync_n),
        .async_in(pad_in),
        .level(pad_input_level) // see R05
    );

    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
        addr_hit = (addr == target);
    endfunction : addr_hit

    assign hit_enable = addr_hit(reg_address, ADDR_PAD_OUTPUT_ENABLE);
    assign hit_value = addr_hit(reg_address, ADDR_PAD_OUTPUT_VALUE);
    assign hit_input = addr_hit(reg_address, ADDR_PAD_INPUT_LEVEL);
    assign hit_select = addr_hit(reg_address, ADDR_MONITOR_OUTPUT_SELECT);

    // reserved bits 6..4 read as zero
    assign select_readback = {fast_switch, 3'h0, monitor_select_field}; // see R15

    // unmapped addresses read zero
    assign next_read_data = !reg_read ? 8'h00 :
                            hit_enable ? pad_output_enable :
                            hit_value ? pad_output_value :
                            hit_input ? pad_input_level : // see R05 R06
                            hit_select ? select_readback : 8'h00;

    // scan pins stay with the scan interface when scan is strapped on
    assign effective_enable = scan_active ? (pad_output_enable & ~SCAN_PIN_MASK)
                                          : pad_output_enable; // see R01 R03
    assign next_pad_out = pad_output_value; // see R04 R06

    always_ff @(posedge clock or negedge reset_sync_n) begin
        if (!reset_sync_n) begin
            pad_output_enable <= PAD_RESET; // see R15
            pad_output_value <= PAD_RESET;
            fast_switch <= 1'b0;
            monitor_select_field <= SEL_RESET;
        end else if (reg_write) begin
            if (hit_enable) begin
                pad_output_enable <= reg_write_data;
            end
            if (hit_value) begin
                pad_output_value <= reg_write_data;
            end
            if (hit_select) begin
                fast_switch <= reg_write_data[FAST_SWITCH_BIT]; // see R07
                monitor_select_field <= reg_write_data[SEL_MSB:SEL_LSB];
            end
        end
    end

    // monitor pin source, decoded from the select field
    always_comb begin
        next_monitor_value = 1'b0;
        next_monitor_drive = 1'b1;
        case (monitor_select_field)
            SEL_TRI_A, SEL_TRI_B: begin
                next_monitor_drive = 1'b0; // see R08
            end
            SEL_LOW: begin
                next_monitor_value = 1'b0; // see R09
            end
            SEL_HIGH: begin
                next_monitor_value = 1'b1; // see R09
            end
            SEL_TX_ENVELOPE: begin
                next_monitor_value = tx_envelope; // see R10
            end
            SEL_TX_ACTIVE: begin
                next_monitor_value = tx_active; // see R10
            end
            SEL_COPROC_LINK: begin
                next_monitor_value = secure_coprocessor_link_signal; // see R11
            end
            SEL_RX_ENVELOPE: begin
                // only meaningful in type A reception at 106 kBd
                next_monitor_value = rx_envelope; // see R12
            end
            SEL_RX_ACTIVE: begin
                next_monitor_value = rx_active; // see R13
            end
            SEL_RX_BIT: begin
                next_monitor_value = rx_bit; // see R13
            end
            default: begin
                next_monitor_drive = 1'b0; // see R14
            end
        endcase
    end

    // registered pin drive costs one cycle of latency on monitored signals
    always_ff @(posedge clock or negedge reset_sync_n) begin
        if (!reset_sync_n) begin
            reg_read_data <= 8'h00;
            pad_out <= PAD_RESET;
            pad_oe_n <= 8'hFF;
            clock_output_function_off <= 1'b0;
            fast_switch_bit <= 1'b0;
            monitor_output_pin_out <= 1'b0;
            monitor_output_pin_oe_n <= 1'b1;
        end else begin
            reg_read_data <= next_read_data;
            pad_out <= next_pad_out;
            pad_oe_n <= ~effective_enable;
            clock_output_function_off <= pad_output_enable[PIN_CLOCK_OUTPUT]; // see R02
            fast_switch_bit <= fast_switch; // see R07
            monitor_output_pin_out <= next_monitor_value;
            monitor_output_pin_oe_n <= ~next_monitor_drive;
        end
    end

    // clock output function is not routed to any pin here; only clock_output_function_off leaves this block
    logic unused_clock_function;
    assign unused_clock_function = clock_output_function;
endmodule : pgm_pad_monitor

// [logic/pgm_pkg.sv]
// Purpose: constants for the pad configuration and signal monitor block
// Assumes: byte-wide register port, printed offsets used directly
// Notes: bit order is shared by all three pad registers
package pgm_pkg;
    localparam logic [7:0] ADDR_PAD_OUTPUT_ENABLE = 8'h44;
    localparam logic [7:0] ADDR_PAD_OUTPUT_VALUE = 8'h45;
    localparam logic [7:0] ADDR_PAD_INPUT_LEVEL = 8'h46;
    localparam logic [7:0] ADDR_MONITOR_OUTPUT_SELECT = 8'h47;
    localparam int PAD_COUNT = 8;
    localparam int PIN_AUX_SIGNAL_INPUT = 7;
    localparam int PIN_CLOCK_OUTPUT = 6;
    localparam int PIN_HOST_SELECT_1 = 5;
    localparam int PIN_HOST_SELECT_0 = 4;
    localparam int PIN_TCK = 3;
    localparam int PIN_TMS = 2;
    localparam int PIN_TDI = 1;
    localparam int PIN_TDO = 0;
    localparam logic [7:0] SCAN_PIN_MASK = 8'h0F;
    localparam int FAST_SWITCH_BIT = 7;
    localparam int SEL_MSB = 3;
    localparam int SEL_LSB = 0;
    localparam logic [7:0] PAD_RESET = 8'h00;
    localparam logic [3:0] SEL_RESET = 4'h0;
    localparam logic [3:0] SEL_TRI_A = 4'h0;
    localparam logic [3:0] SEL_TRI_B = 4'h1;
    localparam logic [3:0] SEL_LOW = 4'h2;
    localparam logic [3:0] SEL_HIGH = 4'h3;
    localparam logic [3:0] SEL_TX_ENVELOPE = 4'h4;
    localparam logic [3:0] SEL_TX_ACTIVE = 4'h5;
    localparam logic [3:0] SEL_COPROC_LINK = 4'h6;
    localparam logic [3:0] SEL_RX_ENVELOPE = 4'h7;
    localparam logic [3:0] SEL_RX_ACTIVE = 4'h8;
    localparam logic [3:0] SEL_RX_BIT = 4'h9;
endpackage : pgm_pkg

// [logic/pgm_sync.sv]
// Purpose: three-stage synchroniser for a vector of pin levels
// Assumes: inputs asynchronous to clock
// Notes: a bit changes only once stages two and three agree
`timescale 1ns/1ps
module pgm_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] level
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] agree;
    logic [WIDTH-1:0] next_level;

    assign agree = ~(stage2 ^ stage3);
    assign next_level = (agree & stage3) | (~agree & level);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            level <= '0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
            level <= next_level;
        end
    end
endmodule : pgm_sync

// [sim/pgm_board.sv]
// Purpose: board circuitry on the eight multi-purpose pins
// Assumes: no pull resistors on the pins
// Notes: a released, undriven pin toggles so stale levels never pass
`timescale 1ns/1ps
module pgm_board (
    input wire logic clock,
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe_n,
    input wire logic [7:0] drv_en,
    input wire logic [7:0] drv_val,
    output logic [7:0] pad_in
);
    logic [7:0] float_q = 8'h00;
    always_ff @(posedge clock) float_q <= ~float_q;
    assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & drv_en & drv_val)
        | (pad_oe_n & ~drv_en & float_q);
endmodule : pgm_board

// [sim/pgm_pad_monitor_assertions.sv]
// Purpose: port-level checks for the pad and monitor block
// Assumes: monitor select tracked from observed register writes
// Notes: bound into every instance of the top module
`timescale 1ns/1ps
module pgm_pad_monitor_assertions (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [7:0] reg_address,
    input wire logic [7:0] reg_write_data,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_read_data,
    input wire logic boundary_scan_active,
    input wire logic [7:0] pad_in,
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe_n,
    input wire logic clock_output_function_off,
    input wire logic fast_switch_bit,
    input wire logic tx_envelope,
    input wire logic tx_active,
    input wire logic secure_coprocessor_link_signal,
    input wire logic rx_envelope,
    input wire logic rx_active,
    input wire logic rx_bit,
    input wire logic monitor_output_pin_out,
    input wire logic monitor_output_pin_oe_n
);
    logic [3:0] sel_q;
    logic src;
    always_ff @(posedge clock or negedge reset_n)
        if (!reset_n) sel_q <= 4'h0;
        else if (reg_write && reg_address == 8'h47) sel_q <= reg_write_data[3:0];
    // constant codes fall to the default: lsb is the level
    always_comb
        case (sel_q)
            4'h4: src = tx_envelope;
            4'h5: src = tx_active;
            4'h6: src = secure_coprocessor_link_signal;
            4'h7: src = rx_envelope;
            4'h8: src = rx_active;
            4'h9: src = rx_bit;
            default: src = sel_q[0];
        endcase
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    sequence s_wr(logic [7:0] a);
        reg_write && reg_address == a;
    endsequence
    chk_oe_write: assert property (s_wr(8'h44) |-> ##2
        pad_oe_n[7:4] == ~$past(reg_write_data[7:4], 2)) else $error("enable write lost");
    chk_clock_output_pin_off: assert property (s_wr(8'h44) |-> ##2
        clock_output_function_off == $past(reg_write_data[6], 2)) else $error("clock out bad");
    chk_scan_mask: assert property (boundary_scan_active [*6] |->
        pad_oe_n[3:0] == 4'hF) else $error("scan pins driven");
    chk_value_write: assert property (s_wr(8'h45) |-> ##2
        pad_out == $past(reg_write_data, 2)) else $error("pad value lost");
    chk_input_read: assert property (($stable(pad_in) [*8]) ##0
        (reg_read && reg_address == 8'h46) |=> reg_read_data == $past(pad_in))
        else $error("pin levels misread");
    chk_speed_write: assert property (s_wr(8'h47) |-> ##2
        fast_switch_bit == $past(reg_write_data[7], 2)) else $error("speed bit lost");
    chk_mon_tristate: assert property (!(sel_q inside {[4'h2:4'h9]}) |=>
        monitor_output_pin_oe_n) else $error("monitor pin driven");
    chk_mon_drive: assert property (sel_q inside {[4'h2:4'h9]} |=>
        !monitor_output_pin_oe_n && monitor_output_pin_out == $past(src))
        else $error("monitor pin wrong");
    chk_unmapped_read: assert property (reg_read &&
        !(reg_address inside {[8'h44:8'h47]}) |=> reg_read_data == 8'h00)
        else $error("unmapped read not zero");
endmodule : pgm_pad_monitor_assertions
bind pgm_pad_monitor pgm_pad_monitor_assertions i_chk (.clock, .reset_n, .reg_address,
    .reg_write_data, .reg_write, .reg_read, .reg_read_data, .boundary_scan_active, .pad_in,
    .pad_out, .pad_oe_n, .clock_output_function_off, .fast_switch_bit, .tx_envelope,
    .tx_active, .secure_coprocessor_link_signal, .rx_envelope, .rx_active, .rx_bit,
    .monitor_output_pin_out, .monitor_output_pin_oe_n);

// [sim/pgm_pad_monitor_tb.sv]
// Purpose: self-checking bench for the pad and monitor block
// Assumes: board model drives the pins the device releases
// Notes: monitor codes swept from a table, pad cases by hand
`timescale 1ns/1ps
module pgm_pad_monitor_tb;
    logic clock = 0, reset_n = 0, reg_write = 0, reg_read = 0, boundary_scan_active = 0;
    logic [7:0] reg_address = 8'h00, reg_write_data = 8'h00, drv_en = 8'h00, drv_val = 8'h00;
    logic tx_envelope = 0, tx_active = 0, secure_coprocessor_link_signal = 0;
    logic rx_envelope = 0, rx_active = 0, rx_bit = 0;
    logic [7:0] reg_read_data, pad_in, pad_out, pad_oe_n;
    logic clock_output_function_off, fast_switch_bit;
    logic monitor_output_pin_out, monitor_output_pin_oe_n;
    int fails = 0, samples_checked = 0, cycles = 0;
    // code, sources, pin released, pin level
    logic [11:0] rows [16] = '{12'h002, 12'h102, 12'h2FC, 12'h301, 12'h4F8, 12'h5F4,
        12'h6EC, 12'h7DC, 12'h8BC, 12'h97C, 12'hA02, 12'hB02, 12'hC02, 12'hD02,
        12'hE02, 12'hF02};
    pgm_pad_monitor i_dut (.clock, .reset_n, .reg_address, .reg_write_data, .reg_write,
        .reg_read, .reg_read_data, .boundary_scan_active, .pad_in, .pad_out, .pad_oe_n,
        .clock_output_function_off, .fast_switch_bit, .clock_output_function(1'b0),
        .tx_envelope, .tx_active, .secure_coprocessor_link_signal, .rx_envelope, .rx_active,
        .rx_bit, .monitor_output_pin_out, .monitor_output_pin_oe_n);
    pgm_board i_board (.clock, .pad_out, .pad_oe_n, .drv_en, .drv_val, .pad_in);
    initial begin
        forever #4 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            fails++;
            wrap_up();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_address <= a;
        reg_write_data <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr
    task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp8
    task automatic cmp1(input logic g, input logic e);
        cmp8({7'h00, g}, {7'h00, e});
    endtask : cmp1
    // read data stand only in the cycle after the strobe
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_address <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 cmp8(reg_read_data, e);
    endtask : chk_rd
    task automatic wrap_up();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        tick(3);
        cmp8(pad_oe_n, 8'hFF);
        cmp1(monitor_output_pin_oe_n, 1'b1);
        cmp8(pad_out, 8'h00);
        cmp1(clock_output_function_off, 1'b0);
        cmp1(fast_switch_bit, 1'b0);
        chk_rd(8'h44, 8'h00);
        chk_rd(8'h45, 8'h00);
        chk_rd(8'h47, 8'h00);
        $display("reset test done");
        foreach (rows[i]) begin
            @(posedge clock);
            {rx_bit, rx_active, rx_envelope, secure_coprocessor_link_signal, tx_active,
                tx_envelope} <= rows[i][7:2];
            // reserved bits written as ones must read back zero
            wr(8'h47, {rows[i][8], 3'h7, rows[i][11:8]});
            tick(3);
            cmp1(monitor_output_pin_oe_n, rows[i][1]);
            if (!rows[i][1]) begin
                cmp1(monitor_output_pin_out, rows[i][0]);
            end
            cmp1(fast_switch_bit, rows[i][8]);
            chk_rd(8'h47, {rows[i][8], 3'h0, rows[i][11:8]});
        end
        $display("monitor table done");
        @(posedge clock);
        drv_en <= 8'h0F;
        drv_val <= 8'h03;
        wr(8'h44, 8'h40);
        tick(3);
        cmp8(pad_oe_n, 8'hBF);
        cmp1(clock_output_function_off, 1'b1);
        wr(8'h45, 8'hA5);
        wr(8'h44, 8'hF0);
        tick(3);
        cmp8(pad_oe_n, 8'h0F);
        cmp8(pad_out, 8'hA5);
        chk_rd(8'h44, 8'hF0);
        chk_rd(8'h45, 8'hA5);
        tick(8);
        chk_rd(8'h46, 8'hA3);
        wr(8'h46, 8'h00);
        chk_rd(8'h46, 8'hA3);
        chk_rd(8'h48, 8'h00);
        @(posedge clock);
        boundary_scan_active <= 1'b1;
        tick(6);
        wr(8'h44, 8'hFF);
        tick(3);
        cmp8(pad_oe_n, 8'h0F);
        $display("pad tests done");
        // mid-run reset must clear the value and select registers, the speed bit and enable bit 6 written above
        @(posedge clock);
        reset_n <= 1'b0;
        tick(2);
        cmp8(pad_oe_n, 8'hFF);
        @(posedge clock);
        reset_n <= 1'b1;
        tick(3);
        cmp8(pad_out, 8'h00);
        cmp1(fast_switch_bit, 1'b0);
        cmp1(clock_output_function_off, 1'b0);
        chk_rd(8'h45, 8'h00);
        chk_rd(8'h47, 8'h00);
        // scan strap still high, so it must resync and mask again
        wr(8'h44, 8'h0F);
        tick(3);
        cmp8(pad_oe_n, 8'hFF);
        $display("mid-run reset test done");
        wrap_up();
    end
endmodule : pgm_pad_monitor_tb
